// [core/aae_consts.vh]
/*
  Constants for the register-add execute block: opcode fields, address
  rules and flag positions. Assumes inclusion by bare name from core files.
*/
`ifndef AAE_CONSTS_VH
`define AAE_CONSTS_VH
`define AAE_OPCODE 6'h09
`define AAE_OPC_HI 15
`define AAE_OPC_LO 10
`define AAE_DEST_BIT 9
`define AAE_ACCESS_BIT 8
`define AAE_INDEXED_MAX 8'h5f
`define AAE_ACCESS_SPLIT 8'h60
`define AAE_ACCESS_BANK 4'hf
`define AAE_OPERAND_HI 7
`define AAE_OPERAND_LO 0
`define AAE_ACC_RESET 8'h00
`define AAE_STATUS_RESET 5'h00
`define AAE_FLAG_C 0
`define AAE_FLAG_DIGIT_CARRY 1
`define AAE_FLAG_Z 2
`define AAE_FLAG_OVERFLOW 3
`define AAE_FLAG_N 4
`endif

// [core/aae_data_mem.v]
/*
  Small data memory of 4096 bytes with registered read data.
  Assumes a single clock; write and read may occur in the same cycle.
*/
`timescale 1ns/10ps
module aae_data_mem (
  input wire clk,
  input wire wr_en,
  input wire [11:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [11:0] rd_addr,
  output reg [7:0] rd_data
);
  reg [7:0] mem [0:4095];

  // Write port and registered read port.
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// [core/aae_exec.v]
/*
  Decode and execute of the register-add instruction of an 8-bit core.
  The block keeps the accumulator, the status flags and a private data
  memory, and runs each add in three steps: take, operand read and write.
  Assumes an instruction word presented with a one-cycle start pulse, and
  that the surrounding core keeps the bank select and pointer registers.
  Assumes the instruction word, the bank and the pointer need only be valid
  in the cycle of the start pulse, because the operand address is latched.
  Assumes preload writes and accumulator loads are made while idle.
*/
`timescale 1ns/10ps
`include "aae_consts.vh"

// Overview of operation
// - Recognise the add when the top six bits match the fixed opcode.
// - Add accumulator and addressed memory register, deliver sum to destination.
// - Destination bit clear writes sum to accumulator, register untouched.
// - Destination bit set writes sum back into the addressed register.
// - Access clear and extended set enabled: operands up to 95 are indexed.
module aae_exec (
  input wire clk,
  input wire rst,
  input wire start,
  input wire [15:0] instr,
  input wire ext_set_en,
  input wire [3:0] bank_select_reg,
  input wire [11:0] index_base,
  input wire acc_load,
  input wire [7:0] acc_load_data,
  input wire mem_wr_en,
  input wire [11:0] mem_wr_addr,
  input wire [7:0] mem_wr_data,
  output reg [7:0] acc,
  output reg [4:0] status,
  output reg busy,
  output reg done,
  output reg illegal
);
  // State codes of the execute sequencer.
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_READ = 2'h1;
  localparam [1:0] ST_WRITE = 2'h2;

  // Sequencer state and the operands latched when an add is taken.
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [11:0] addr_reg;
  reg dest_reg;
  reg [7:0] acc_reg;

  // Data memory port steering.
  reg [11:0] rd_addr;
  reg wr_en;
  reg [11:0] wr_addr;
  reg [7:0] wr_data;
  wire [7:0] rd_data;

  // Adder results and the flag values they give.
  wire [8:0] sum9;
  wire [4:0] low5;
  wire [7:0] sum8;
  wire carry_res;
  wire digit_carry_res;
  wire zero_res;
  wire negative_res;
  wire overflow_res;

  // Instruction fields and the take and refuse conditions.
  wire is_add;
  wire dest_bit;
  wire access_bit;
  wire [7:0] operand_f;
  wire take_add;
  wire refuse_op;

  // Effective address: indexed, access bank, or banked.
  function [11:0] eff_addr;
    input [7:0] f;
    input a;
    input ext;
    input [3:0] bank;
    input [11:0] base;
    begin
      if (!a && ext && f <= `AAE_INDEXED_MAX) begin
        eff_addr = base + {4'h0, f};
      end else if (!a) begin
        eff_addr = (f < `AAE_ACCESS_SPLIT) ? {4'h0, f} : {`AAE_ACCESS_BANK, f};
      end else begin
        eff_addr = {bank, f};
      end
    end
  endfunction

  // Field decode of the instruction word.
  assign is_add = (instr[`AAE_OPC_HI:`AAE_OPC_LO] == `AAE_OPCODE);
  assign dest_bit = instr[`AAE_DEST_BIT];
  assign access_bit = instr[`AAE_ACCESS_BIT];
  assign operand_f = instr[`AAE_OPERAND_HI:`AAE_OPERAND_LO];

  // An add is taken only from idle; any other word offered in idle is refused.
  assign take_add = (state_reg == ST_IDLE) && start && is_add;
  assign refuse_op = (state_reg == ST_IDLE) && start && !is_add;

  aae_data_mem u_aae_data_mem (
    .clk(clk),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // Adder and partial sums for carries.
  assign sum9 = {1'b0, acc_reg} + {1'b0, rd_data};
  assign low5 = {1'b0, acc_reg[3:0]} + {1'b0, rd_data[3:0]};
  assign sum8 = sum9[7:0];

  // Flag values of the 8-bit sum; overflow means two like signs gave the other sign.
  assign carry_res = sum9[8];
  assign digit_carry_res = low5[4];
  assign zero_res = (sum8 == 8'h00);
  assign negative_res = sum8[7];
  assign overflow_res = (acc_reg[7] == rd_data[7]) && (sum8[7] != acc_reg[7]);

  // Sequencer: idle until an add is taken, then read the operand and write back.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take_add) begin
          state_next = ST_READ;
        end
      end
      ST_READ: begin
        state_next = ST_WRITE;
      end
      ST_WRITE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Memory port steering. The read address follows the instruction word only
  // in idle; during the add it comes from the latched address, so a new word
  // on the instruction input cannot change the operand in mid-flight.
  always @* begin
    if (state_reg == ST_IDLE) begin
      rd_addr = eff_addr(operand_f, access_bit, ext_set_en, bank_select_reg, index_base);
    end else begin
      rd_addr = addr_reg;
    end
    wr_en = mem_wr_en;
    wr_addr = mem_wr_addr;
    wr_data = mem_wr_data;
    if (state_reg == ST_WRITE && dest_reg) begin
      wr_en = 1'b1;
      wr_addr = addr_reg;
      wr_data = sum8;
    end
  end

  // Sequencer state register.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Operand address and destination, latched in the cycle an add is taken.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_reg <= 12'h000;
      dest_reg <= 1'b0;
    end else if (take_add) begin
      addr_reg <= rd_addr;
      dest_reg <= dest_bit;
    end
  end

  // Accumulator: written by an add with the destination bit clear, or loaded
  // from outside while idle. The output copy keeps the port on a flip-flop.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg <= `AAE_ACC_RESET;
      acc <= `AAE_ACC_RESET;
    end else if (state_reg == ST_WRITE) begin
      if (!dest_reg) begin
        acc_reg <= sum8;
        acc <= sum8;
      end
    end else if (acc_load && state_reg == ST_IDLE) begin
      acc_reg <= acc_load_data;
      acc <= acc_load_data;
    end
  end

  // Status flags follow every add, whichever destination it writes.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= `AAE_STATUS_RESET;
    end else if (state_reg == ST_WRITE) begin
      status[`AAE_FLAG_C] <= carry_res;
      status[`AAE_FLAG_DIGIT_CARRY] <= digit_carry_res;
      status[`AAE_FLAG_Z] <= zero_res;
      status[`AAE_FLAG_OVERFLOW] <= overflow_res;
      status[`AAE_FLAG_N] <= negative_res;
    end
  end

  // Handshake outputs: busy while the add runs, done and illegal for one cycle.
  // A start offered while busy is dropped without any mark.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      illegal <= 1'b0;
    end else begin
      busy <= (state_next != ST_IDLE);
      done <= (state_reg == ST_WRITE);
      illegal <= refuse_op;
    end
  end
endmodule

// [testbench/aae_exec_monitor.sv]
/* Port checker for the register-add execute block.
   Assumes one clock and an active-high asynchronous reset. */
`timescale 1ns/10ps
module aae_exec_monitor (
  input wire clk,
  input wire rst,
  input wire start,
  input wire [15:0] instr,
  input wire acc_load,
  input wire busy,
  input wire done,
  input wire illegal,
  input wire [7:0] acc,
  input wire [4:0] status
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // An add is taken when idle and the opcode matches.
  wire take = start && !busy && instr[15:10] == 6'h09;
  a_add_timing: assert property (take |=> busy ##1 busy ##1 done && !busy)
    else $error("add timing wrong");
  a_illegal_op: assert property (start && !busy && !take |=> illegal && !busy)
    else $error("non-add not refused");
  a_zero_flag: assert property (take && !instr[9] |-> ##3 status[2] == (acc == 8'h00))
    else $error("zero flag wrong");
  a_acc_sum: assert property (take && !instr[9] |-> ##3 done && status[4] == acc[7])
    else $error("sum not in accumulator");
  a_reg_dest: assert property (take && instr[9] && !acc_load |=> $stable(acc) [*3])
    else $error("accumulator changed");
  a_done_pulse: assert property (done |=> !done)
    else $error("done too long");
  c_to_acc: cover property (take && !instr[9]);
  c_to_reg: cover property (take && instr[9]);
  c_refused: cover property (illegal);
endmodule

bind aae_exec aae_exec_monitor u_mon (.clk(clk), .rst(rst), .start(start), .instr(instr),
  .acc_load(acc_load), .busy(busy), .done(done), .illegal(illegal), .acc(acc),
  .status(status));

// [testbench/add_to_accumulator_exec_test.sv]
/* Self-checking bench for the register-add execute block.
   Assumes the memory is preloaded through the write port. */
`timescale 1ns/10ps
module add_to_accumulator_exec_test;
  reg clk = 0, rst = 1, start = 0, ext = 0, ld = 0, we = 0;
  reg [15:0] instr = 0;
  reg [3:0] bank = 4'h2;
  reg [11:0] wa = 0;
  reg [7:0] ldd = 0, wd = 0;
  wire [7:0] acc;
  wire [4:0] status;
  wire busy, done, illegal;
  integer fails = 0, n_checks = 0, n;
  aae_exec u_aae_exec (.clk(clk), .rst(rst), .start(start), .instr(instr),
    .ext_set_en(ext), .bank_select_reg(bank), .index_base(12'h300), .acc_load(ld),
    .acc_load_data(ldd), .mem_wr_en(we), .mem_wr_addr(wa), .mem_wr_data(wd),
    .acc(acc), .status(status), .busy(busy), .done(done), .illegal(illegal));
  task end_of_test;
    begin
      if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Preload one memory byte, then the accumulator, at falling edges.
  task prep(input [11:0] a, input [7:0] d, input [7:0] w);
    begin
      we = 1;
      wa = a;
      wd = d;
      @(negedge clk) we = 0;
      ld = 1;
      ldd = w;
      @(negedge clk) ld = 0;
    end
  endtask
  // Issue one instruction and judge the accumulator and flags at done.
  task run(input [15:0] i, input [7:0] ea, input [4:0] es);
    begin
      start = 1;
      instr = i;
      @(negedge clk) start = 0;
      chk({7'h0, busy}, 8'h01);
      n = 0;
      while (done !== 1'b1 && n < 8) begin
        @(negedge clk) n = n + 1;
      end
      chk({7'h0, done}, 8'h01);
      chk(acc, ea);
      chk({3'h0, status}, {3'h0, es});
    end
  endtask
  task t_to_acc;
    begin
      prep(12'h234, 8'hc2, 8'h17);
      run(16'h2534, 8'hd9, 5'h10);
      prep(12'h2ff, 8'hff, 8'h01);
      run(16'h25ff, 8'h00, 5'h07);
    end
  endtask
  task t_to_reg;
    begin
      prep(12'h2a0, 8'h8f, 8'h8f);
      run(16'h27a0, 8'h8f, 5'h0b);
      prep(12'h000, 8'h00, 8'h00);
      run(16'h25a0, 8'h1e, 5'h00);
    end
  endtask
  task t_indexed;
    begin
      ext = 1;
      prep(12'h05f, 8'h40, 8'h00);
      prep(12'h35f, 8'h01, 8'h00);
      run(16'h245f, 8'h01, 5'h00);
      prep(12'hf60, 8'h10, 8'h00);
      run(16'h2460, 8'h10, 5'h00);
      ext = 0;
      prep(12'h000, 8'h00, 8'h00);
      run(16'h245f, 8'h40, 5'h00);
    end
  endtask
  task t_refused;
    begin
      prep(12'h000, 8'h00, 8'h55);
      start = 1;
      instr = 16'h0000;
      @(negedge clk) start = 0;
      chk({7'h0, illegal}, 8'h01);
      @(negedge clk) chk(acc, 8'h55);
    end
  endtask
  // Free-running clock.
  initial forever #5 clk = ~clk;
  // Watchdog against a hang.
  initial begin
    #20000 fails = fails + 1;
    end_of_test;
  end
  // Reset, then the scenarios in turn.
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    t_to_acc;
    t_to_reg;
    t_indexed;
    t_refused;
    end_of_test;
  end
endmodule
